// [logic/swpc_pkg.sv]
// shared constants and types of the sleep/wake power controller
`default_nettype none
package swpc_pkg;

	// clock and wake timing
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
	localparam int unsigned OST_TIME_NS     = 1500;
	localparam int unsigned LOCK_TIME_NS    = 2000;
	localparam int unsigned MONITOR_TIME_NS = 3000;
	localparam int unsigned OST_CYC  = (OST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MON_CYC  = (MONITOR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  OST_CNT  = 8'(OST_CYC);
	localparam logic [7:0]  LOCK_CNT = 8'(LOCK_CYC);
	localparam logic [7:0]  MON_CNT  = 8'(MON_CYC);

	// register byte offsets
	localparam logic [7:0] RCC_OFFSET    = 8'h00;
	localparam logic [7:0] CFG_OFFSET    = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;

	// reset_cause_control fields
	localparam int unsigned RCC_POR_BIT   = 0;
	localparam int unsigned RCC_BOR_BIT   = 1;
	localparam int unsigned RCC_IDLE_BIT  = 2;
	localparam int unsigned RCC_SLEEP_BIT = 3;
	localparam int unsigned RCC_WATCHDOG_TIMEOUT_FLAG_BIT  = 4;
	localparam int unsigned RCC_SWR_BIT   = 6;
	localparam int unsigned RCC_EXTERNAL_RESET_FLAG_BIT  = 7;
	localparam logic [31:0] RCC_MASK      = 32'h0000_03DF;
	localparam logic [31:0] RCC_RESET     = 32'h0000_0001;

	// power configuration fields
	localparam int unsigned CFG_SECONDARY_OSCILLATOR_EN_BIT = 1;
	localparam int unsigned CFG_SLEEP_BIT   = 4;
	localparam int unsigned CFG_MON_EN_BIT  = 5;
	localparam int unsigned CFG_XTAL_BIT    = 6;
	localparam int unsigned CFG_CF_BIT      = 8;
	localparam int unsigned CFG_SRC_LSB     = 12;
	localparam logic [31:0] CFG_MASK        = 32'h0000_7172;
	localparam logic [31:0] CFG_RESET       = 32'h0000_0000;

	// status fields
	localparam int unsigned STS_READY_BIT = 5;
	localparam int unsigned STS_CNT_LSB   = 8;
	localparam int unsigned STS_SRC_LSB   = 16;

	localparam int unsigned NUM_SLEEP_PERIPH = 5;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	typedef enum logic [2:0] {
		SRC_FRC      = 3'h0,
		SRC_FRC_PLL  = 3'h1,
		SRC_PRIMARY_OSCILLATOR     = 3'h2,
		SRC_PRIMARY_OSCILLATOR_PLL = 3'h3,
		SRC_SECONDARY_OSCILLATOR     = 3'h4,
		SRC_LOW_POWER_INTERNAL_RC     = 3'h5,
		SRC_FRC_D16  = 3'h6,
		SRC_FRC_DIV  = 3'h7
	} swpc_src_t;

	typedef enum logic [3:0] {
		ST_RUN   = 4'h1,
		ST_IDLE  = 4'h2,
		ST_SLEEP = 4'h4,
		ST_WAKE  = 4'h8
	} swpc_state_t;

endpackage : swpc_pkg
`default_nettype wire

// [logic/swpc_power_ctrl.sv]
// sleep/wake power sequencer with wake-cause register and axi4-lite slave
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module swpc_power_ctrl
	import swpc_pkg::*;
(
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write channels
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// axi4-lite read channels
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// processor core and interrupt controller
	input  wire logic                        wait_exec,
	input  wire logic                        irq_pending,
	input  wire logic                        irq_in_sleep,
	input  wire logic [2:0]                  irq_prio,
	input  wire logic [2:0]                  cpu_prio,
	output logic                             cpu_halt,
	output logic                             clk_release,
	output logic                             clk_fail_trap,
	// reset and watchdog events
	input  wire logic                        ext_reset_evt,
	input  wire logic                        sw_reset_evt,
	input  wire logic                        brownout_reset,
	input  wire logic                        watchdog_timeout,
	input  wire logic                        brownout_enable,
	output logic                             brownout_active,
	// oscillators
	input  wire logic                        usb_keep_osc,
	input  wire logic                        low_power_internal_rc_in_use,
	input  wire logic                        osc_ready,
	output logic                             primary_oscillator_run,
	output logic                             frc_run,
	output logic                             secondary_oscillator_run,
	output logic                             low_power_internal_rc_run,
	output logic [2:0]                       active_src,
	output logic                             monitor_active,
	// peripherals
	input  wire logic [NUM_SLEEP_PERIPH-1:0] sleep_periph_cfg,
	output logic [NUM_SLEEP_PERIPH-1:0]      periph_run,
	output logic                             peripheral_bus_clock_en
);

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return r;
	endfunction : apply_strb

	// {need, cycles} of oscillator delay on leaving sleep
	function automatic logic [8:0] wake_delay(input swpc_src_t src, input logic xtal,
			input logic primary_oscillator_kept, input logic secondary_oscillator_kept);
		logic [7:0] c;
		c = 8'h00;
		unique case (src)
			SRC_PRIMARY_OSCILLATOR:     c = (xtal && !primary_oscillator_kept) ? OST_CNT : 8'h00;
			SRC_PRIMARY_OSCILLATOR_PLL: c = primary_oscillator_kept ? 8'h00 :
				(xtal ? 8'(OST_CNT + LOCK_CNT) : LOCK_CNT);
			SRC_FRC_PLL:  c = LOCK_CNT;
			SRC_SECONDARY_OSCILLATOR:     c = secondary_oscillator_kept ? 8'h00 : OST_CNT;
			SRC_FRC, SRC_LOW_POWER_INTERNAL_RC, SRC_FRC_D16, SRC_FRC_DIV: c = 8'h00;
		endcase
		return {c != 8'h00, c};
	endfunction : wake_delay

	// ---------------- register bus ----------------
	logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0]  aw_addr_q, aw_addr_d, ar_addr;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0]  w_strb_q, w_strb_d;
	logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic        arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic        do_write;

	logic [31:0] rcc_q, rcc_d, cfg_q, cfg_d, status_w;

	assign do_write = aw_full_q && w_full_q && !bvalid_q;
	assign ar_addr  = s_axi_araddr;

	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d  = w_full_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		if (s_axi_awvalid && awready_q) begin
			aw_full_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_full_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = (aw_addr_q == RCC_OFFSET || aw_addr_q == CFG_OFFSET ||
				aw_addr_q == STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		awready_d = !aw_full_d && !bvalid_d;
		wready_d  = !w_full_d && !bvalid_d;
	end

	always_comb begin
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rresp_d   = RESP_OKAY;
			unique case (ar_addr)
				RCC_OFFSET:    rdata_d = rcc_q;
				CFG_OFFSET:    rdata_d = cfg_q;
				STATUS_OFFSET: rdata_d = status_w;
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q  <= w_full_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// ---------------- sequencer ----------------
	swpc_state_t st_q, st_d;
	logic [7:0]  dly_q, dly_d, mon_q, mon_d;
	logic        need_q, need_d, trap_d;
	logic [8:0]  dly_sel;
	logic        prio_above, rst_any, wake_sleep, wake_idle, sleep_to_idle;
	logic        wake_done, wake_fail, mon_en;
	swpc_src_t   src;

	assign src        = swpc_src_t'(cfg_q[CFG_SRC_LSB +: 3]);
	assign mon_en     = cfg_q[CFG_MON_EN_BIT];
	assign prio_above = irq_prio > cpu_prio;
	assign rst_any    = ext_reset_evt || sw_reset_evt || brownout_reset;
	assign wake_sleep = (irq_pending && irq_in_sleep && prio_above) || rst_any ||
		watchdog_timeout;
	assign sleep_to_idle = irq_pending && irq_in_sleep && !prio_above && !rst_any &&
		!watchdog_timeout;
	assign wake_idle  = (irq_pending && prio_above) || rst_any || watchdog_timeout;
	// running primary_oscillator/secondary_oscillator enables still show their sleep-time state here
	assign dly_sel    = wake_delay(src, cfg_q[CFG_XTAL_BIT], primary_oscillator_run, secondary_oscillator_run);
	// with the monitor off this wait has no bound: the core looks asleep
	assign wake_done  = (dly_q == 8'h00) && (!need_q || osc_ready);
	assign wake_fail  = mon_en && need_q && (mon_q == 8'h00) && !wake_done;

	always_comb begin
		st_d   = st_q;
		dly_d  = (dly_q != 8'h00) ? dly_q - 8'h01 : dly_q;
		mon_d  = (mon_q != 8'h00) ? mon_q - 8'h01 : mon_q;
		need_d = need_q;
		trap_d = 1'b0;
		unique case (st_q)
			ST_RUN: begin
				// watchdog counter is left alone on entry; software services it first
				if (wait_exec) begin
					st_d = cfg_q[CFG_SLEEP_BIT] ? ST_SLEEP : ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (wake_idle) begin
					st_d = ST_RUN;
				end
			end
			ST_SLEEP: begin
				if (wake_sleep) begin
					st_d   = ST_WAKE;
					need_d = dly_sel[8];
					dly_d  = dly_sel[7:0];
					mon_d  = dly_sel[8] ? 8'(dly_sel[7:0] + MON_CNT) : 8'h00;
				end else if (sleep_to_idle) begin
					st_d = ST_IDLE;
				end
			end
			ST_WAKE: begin
				if (wake_fail) begin
					st_d   = ST_RUN;
					trap_d = 1'b1;
				end else if (wake_done) begin
					st_d = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q   <= ST_RUN;
			dly_q  <= 8'h00;
			mon_q  <= 8'h00;
			need_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			dly_q  <= dly_d;
			mon_q  <= mon_d;
			need_q <= need_d;
		end
	end

	// ---------------- registers ----------------
	assign status_w = {13'h0000, src, dly_q, 2'h0, osc_ready, need_q, st_q};

	always_comb begin
		rcc_d = rcc_q;
		cfg_d = cfg_q;
		if (do_write && aw_addr_q == RCC_OFFSET) begin
			rcc_d = apply_strb(rcc_q, w_data_q, w_strb_q) & RCC_MASK;
		end
		if (do_write && aw_addr_q == CFG_OFFSET) begin
			cfg_d = apply_strb(cfg_q, w_data_q, w_strb_q) & CFG_MASK;
		end
		// hardware sets come last so they win over a same-cycle clear
		if (st_q == ST_WAKE && st_d == ST_RUN) begin
			rcc_d[RCC_SLEEP_BIT] = 1'b1;
		end
		if (st_q == ST_IDLE && st_d == ST_RUN) begin
			rcc_d[RCC_IDLE_BIT] = 1'b1;
		end
		if (watchdog_timeout) begin
			rcc_d[RCC_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
		end
		if (ext_reset_evt) begin
			rcc_d[RCC_EXTERNAL_RESET_FLAG_BIT] = 1'b1;
		end
		if (sw_reset_evt) begin
			rcc_d[RCC_SWR_BIT] = 1'b1;
		end
		if (brownout_reset) begin
			rcc_d[RCC_BOR_BIT] = 1'b1;
		end
		if (trap_d) begin
			cfg_d[CFG_CF_BIT]          = 1'b1;
			cfg_d[CFG_SRC_LSB +: 3]    = SRC_FRC;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rcc_q <= RCC_RESET;
			cfg_q <= CFG_RESET;
		end else begin
			rcc_q <= rcc_d;
			cfg_q <= cfg_d;
		end
	end

	// ---------------- registered controls ----------------
	logic                        halt_q, halt_d, rel_q, rel_d, trap_q;
	logic                        primary_oscillator_q, primary_oscillator_d, frc_q, frc_d, secondary_oscillator_q, secondary_oscillator_d, low_power_internal_rc_q, low_power_internal_rc_d;
	logic                        mon_act_q, mon_act_d, bor_q, peripheral_bus_clock_q, peripheral_bus_clock_d;
	logic [2:0]                  asrc_q, asrc_d;
	logic [NUM_SLEEP_PERIPH-1:0] prun_q, prun_d;
	logic                        asleep_d, primary_oscillator_sel, frc_sel;
	swpc_src_t                   src_d;

	always_comb begin
		src_d    = swpc_src_t'(cfg_d[CFG_SRC_LSB +: 3]);
		asleep_d = st_d == ST_SLEEP;
		primary_oscillator_sel = src_d == SRC_PRIMARY_OSCILLATOR || src_d == SRC_PRIMARY_OSCILLATOR_PLL;
		frc_sel  = src_d == SRC_FRC || src_d == SRC_FRC_PLL || src_d == SRC_FRC_D16 ||
			src_d == SRC_FRC_DIV;
		halt_d   = st_d != ST_RUN;
		rel_d    = st_d == ST_RUN;
		peripheral_bus_clock_d  = st_d == ST_RUN || st_d == ST_IDLE;
		primary_oscillator_d   = primary_oscillator_sel && (!asleep_d || usb_keep_osc);
		frc_d    = frc_sel && (!asleep_d || usb_keep_osc);
		secondary_oscillator_d   = (src_d == SRC_SECONDARY_OSCILLATOR && !asleep_d) || cfg_d[CFG_SECONDARY_OSCILLATOR_EN_BIT];
		low_power_internal_rc_d   = (src_d == SRC_LOW_POWER_INTERNAL_RC && !asleep_d) || low_power_internal_rc_in_use;
		mon_act_d = cfg_d[CFG_MON_EN_BIT] && !asleep_d;
		asrc_d   = src_d;
		// in sleep only configured sleep peripherals run, otherwise all run; pad drivers are never gated here
		prun_d   = asleep_d ? sleep_periph_cfg : {NUM_SLEEP_PERIPH{1'b1}};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_q    <= 1'b0;
			rel_q     <= 1'b1;
			trap_q    <= 1'b0;
			peripheral_bus_clock_q   <= 1'b1;
			primary_oscillator_q    <= 1'b0;
			frc_q     <= 1'b1;
			secondary_oscillator_q    <= 1'b0;
			low_power_internal_rc_q    <= 1'b0;
			mon_act_q <= 1'b0;
			bor_q     <= 1'b0;
			asrc_q    <= SRC_FRC;
			prun_q    <= {NUM_SLEEP_PERIPH{1'b1}};
		end else begin
			halt_q    <= halt_d;
			rel_q     <= rel_d;
			trap_q    <= trap_d;
			peripheral_bus_clock_q   <= peripheral_bus_clock_d;
			primary_oscillator_q    <= primary_oscillator_d;
			frc_q     <= frc_d || trap_d;
			secondary_oscillator_q    <= secondary_oscillator_d;
			low_power_internal_rc_q    <= low_power_internal_rc_d;
			mon_act_q <= mon_act_d;
			bor_q     <= brownout_enable;
			asrc_q    <= asrc_d;
			prun_q    <= prun_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign cpu_halt      = halt_q;
	assign clk_release   = rel_q;
	assign clk_fail_trap = trap_q;
	assign brownout_active = bor_q;
	assign primary_oscillator_run      = primary_oscillator_q;
	assign frc_run       = frc_q;
	assign secondary_oscillator_run      = secondary_oscillator_q;
	assign low_power_internal_rc_run      = low_power_internal_rc_q;
	assign active_src    = asrc_q;
	assign monitor_active = mon_act_q;
	assign periph_run    = prun_q;
	assign peripheral_bus_clock_en = peripheral_bus_clock_q;

	// ---------------- assertions ----------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_sleep_entry;
		st_q == ST_RUN && wait_exec && cfg_q[CFG_SLEEP_BIT];
	endsequence
	sequence s_wake_exit;
		st_q == ST_WAKE && !wake_fail && wake_done;
	endsequence

	a_sleep_flag_set: assert property (s_wake_exit |=> rcc_q[RCC_SLEEP_BIT])
		else $error("sleep wake flag not set");
	a_idle_flag_set: assert property (st_q == ST_IDLE && wake_idle |=>
		rcc_q[RCC_IDLE_BIT] && st_q == ST_RUN)
		else $error("idle wake flag not set");
	a_wait_select: assert property (s_sleep_entry |=> st_q == ST_SLEEP ##1 cpu_halt)
		else $error("wait did not enter sleep");
	a_sleep_halts: assert property (st_q == ST_SLEEP && $past(st_q) == ST_SLEEP |->
		cpu_halt && !peripheral_bus_clock_en && !clk_release)
		else $error("core or bus clock running in sleep");
	a_monitor_off: assert property (st_q == ST_SLEEP && $past(st_q) == ST_SLEEP |->
		!monitor_active)
		else $error("monitor active in sleep");
	a_bor_alive: assert property (brownout_enable |=> brownout_active)
		else $error("brown-out detector dropped");
	a_sleep_wake: assert property (st_q == ST_SLEEP && watchdog_timeout |=>
		st_q == ST_WAKE ##0 rcc_q[RCC_WATCHDOG_TIMEOUT_FLAG_BIT])
		else $error("watchdog time-out did not wake");
	a_low_irq_idle: assert property (st_q == ST_SLEEP && sleep_to_idle |=>
		st_q == ST_IDLE && peripheral_bus_clock_en && cpu_halt)
		else $error("low priority interrupt did not move to idle");
	a_primary_oscillator_stops: assert property (st_q == ST_SLEEP && $past(st_q) == ST_SLEEP &&
		!$past(usb_keep_osc) |-> !primary_oscillator_run)
		else $error("primary oscillator runs in sleep");
	a_trap_frc: assert property (st_q == ST_WAKE && wake_fail |=>
		clk_fail_trap && cfg_q[CFG_CF_BIT] && frc_run ##1 !clk_fail_trap)
		else $error("clock failure not trapped");
	a_wait_stable: assert property (st_q == ST_WAKE && !mon_en && !osc_ready && need_q |=>
		st_q == ST_WAKE && !clk_release)
		else $error("released before oscillator stable");
	a_set_wins: assert property (do_write && aw_addr_q == RCC_OFFSET && watchdog_timeout |=>
		rcc_q[RCC_WATCHDOG_TIMEOUT_FLAG_BIT])
		else $error("wake event lost to clear");

endmodule : swpc_power_ctrl
`default_nettype wire

// [bench/swpc_osc_model.sv]
// oscillator model: stable after a warm-up, or never when dead
`default_nettype none
module swpc_osc_model #(
	parameter int WARM = 10
) (
	// clock
	input  wire logic aclk,
	// oscillator control
	input  wire logic primary_oscillator_run,
	input  wire logic dead,
	// status
	output logic      osc_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	// a stopped crystal restarts its warm-up from zero
	always_ff @(posedge aclk) begin
		cnt <= primary_oscillator_run ? cnt + 1 : 0;
	end
	assign osc_ready = !dead && cnt >= WARM;
endmodule : swpc_osc_model
`default_nettype wire

// [bench/test_sleep_wake_power_controller.sv]
// testbench of the sleep/wake power controller
`default_nettype none
module test_sleep_wake_power_controller;
	timeunit 1ns;
	timeprecision 1ns;
	import swpc_pkg::*;
	logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, wait_exec = '0, irq_pending = '0;
	logic irq_in_sleep = '0, ext_reset_evt = '0, sw_reset_evt = '0, brownout_reset = '0;
	logic watchdog_timeout = '0, brownout_enable = '0, usb_keep_osc = '0, low_power_internal_rc_in_use = '0;
	logic dead = '0, tr;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [2:0] irq_prio = 3'h5, cpu_prio = 3'h2, active_src;
	logic [4:0] sleep_periph_cfg = 5'h05, periph_run;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_halt;
	logic clk_release, clk_fail_trap, brownout_active, osc_ready, primary_oscillator_run, frc_run, secondary_oscillator_run;
	logic low_power_internal_rc_run, monitor_active, peripheral_bus_clock_en;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int num_errors = 0;
	int compares = 0;
	int n;
	swpc_power_ctrl DUT (.*);
	swpc_osc_model OSC (.aclk(aclk), .primary_oscillator_run(primary_oscillator_run), .dead(dead), .osc_ready(osc_ready));
	initial forever #25 aclk = ~aclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		chk(s_axi_bresp, r);
		// one idle edge so the next call never reassigns bready in this step
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, r);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask : rd
	task automatic sleep_now(input logic [31:0] c);
		wr(RCC_OFFSET, 32'h0, RESP_OKAY);
		wr(CFG_OFFSET, c, RESP_OKAY);
		wait_exec <= 1'h1;
		@(posedge aclk);
		wait_exec <= 1'h0;
		repeat (4) @(posedge aclk);
	endtask : sleep_now
	// counts edges until release; the trap lasts one cycle so it is caught on the way
	task automatic wait_rel(output int cyc);
		cyc = 0;
		tr = 1'h0;
		while (clk_release !== 1'h1 && cyc < 400) begin
			@(posedge aclk);
			cyc++;
			if (clk_fail_trap === 1'h1) tr = 1'h1;
		end
	endtask : wait_rel
	task automatic wake(output int cyc);
		watchdog_timeout <= 1'h1;
		@(posedge aclk);
		watchdog_timeout <= 1'h0;
		wait_rel(cyc);
	endtask : wake
	task final_report;
		if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : final_report
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(RCC_OFFSET, RCC_RESET, RESP_OKAY);
		rd(CFG_OFFSET, CFG_RESET, RESP_OKAY);
		rd(8'h0C, 32'h0, RESP_SLVERR);
		wr(8'h0C, 32'h0, RESP_SLVERR);
		sleep_now(32'h0);
		chk({cpu_halt, peripheral_bus_clock_en, frc_run}, 3'h7);
		irq_pending <= 1'h1;
		@(posedge aclk);
		irq_pending <= 1'h0;
		wait_rel(n);
		rd(RCC_OFFSET, 32'h4, RESP_OKAY);
		wr(RCC_OFFSET, 32'h0, RESP_OKAY);
		rd(RCC_OFFSET, 32'h0, RESP_OKAY);
		brownout_enable <= 1'h1;
		sleep_now(32'h10);
		chk({cpu_halt, frc_run, monitor_active, brownout_active, peripheral_bus_clock_en,
			periph_run}, 10'h245);
		irq_in_sleep <= 1'h1;
		irq_prio <= 3'h2;
		irq_pending <= 1'h1;
		@(posedge aclk);
		irq_pending <= 1'h0;
		repeat (3) @(posedge aclk);
		chk({cpu_halt, peripheral_bus_clock_en}, 2'h3);
		wake(n);
		rd(RCC_OFFSET, 32'h14, RESP_OKAY);
		sleep_now(32'h10);
		wake(n);
		chk(n <= 5, 1'h1);
		rd(RCC_OFFSET, 32'h18, RESP_OKAY);
		usb_keep_osc <= 1'h1;
		sleep_now(32'h2050);
		chk(primary_oscillator_run, 1'h1);
		wake(n);
		chk({n <= 5, active_src}, 4'hA);
		usb_keep_osc <= 1'h0;
		sleep_now(32'h2050);
		chk(primary_oscillator_run, 1'h0);
		wake(n);
		chk(n >= OST_CYC && n <= OST_CYC + 10, 1'h1);
		dead <= 1'h1;
		sleep_now(32'h2050);
		wake(n);
		chk({clk_release, cpu_halt}, 2'h1);
		dead <= 1'h0;
		wait_rel(n);
		chk({clk_release, tr}, 2'h2);
		dead <= 1'h1;
		sleep_now(32'h2070);
		chk(monitor_active, 1'h0);
		wake(n);
		chk({tr, n >= OST_CYC + MON_CYC && n <= OST_CYC + MON_CYC + 10}, 2'h3);
		rd(CFG_OFFSET, 32'h0170, RESP_OKAY);
		chk(monitor_active, 1'h1);
		watchdog_timeout <= 1'h1;
		wr(RCC_OFFSET, 32'h0, RESP_OKAY);
		watchdog_timeout <= 1'h0;
		rd(RCC_OFFSET, 32'h10, RESP_OKAY);
		irq_prio <= 3'h5;
		sleep_now(32'h10);
		irq_pending <= 1'h1;
		@(posedge aclk);
		irq_pending <= 1'h0;
		wait_rel(n);
		rd(RCC_OFFSET, 32'h8, RESP_OKAY);
		sleep_now(32'h10);
		{ext_reset_evt, sw_reset_evt, brownout_reset} <= 3'h7;
		@(posedge aclk);
		{ext_reset_evt, sw_reset_evt, brownout_reset} <= 3'h0;
		wait_rel(n);
		rd(RCC_OFFSET, 32'hCA, RESP_OKAY);
		sleep_now(32'h4012);
		chk({secondary_oscillator_run, low_power_internal_rc_run}, 2'h2);
		wake(n);
		chk({n <= 5, active_src}, 4'hC);
		low_power_internal_rc_in_use <= 1'h1;
		sleep_now(32'h5010);
		chk({secondary_oscillator_run, low_power_internal_rc_run}, 2'h1);
		low_power_internal_rc_in_use <= 1'h0;
		repeat (2) @(posedge aclk);
		chk(low_power_internal_rc_run, 1'h0);
		wake(n);
		chk(active_src, 3'h5);
		final_report;
	end
endmodule : test_sleep_wake_power_controller
`default_nettype wire
